/* mrtb_timebase.v */
//Contract
//- Relative clock equals absolute plus offset always
//- Offset write moves relative clock immediately
//- Relative write loads clock, recomputes offset
//- Relative clock is 32-bit at 250kHz
//- Trigger compare values untouched by relative writes
//- Completion timestamp captured, clock chosen by select
//- Backoff counter runs 0 to 79, wraps
//- Slotted access only at wrap, every 20 symbols
//- Beacon receive reloads counter from rx offset
//- Transmit reloads counter from tx offset
//- Rx slot offset bits 27-16, quarter symbols
//- Tx slot offset bits 11-0, quarter symbols
//- Rx timestamp after length field, clock selectable
//- Absolute clock 32-bit, 250kHz, software loadable
`timescale 1ns/1ps
`include "mrtb_defines.vh"

module mrtb_timebase #(
	parameter TICK_CYCLES = `MRTB_TICK_CYCLES
) (
	input  wire        CORE_CLK,
	input  wire        RST_N,
	// AXI4-Lite slave
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire [2:0]  S_AXI_AWPROT,
	input  wire        S_AXI_AWVALID,
	output reg         S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output reg         S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire [2:0]  S_AXI_ARPROT,
	input  wire        S_AXI_ARVALID,
	output reg         S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	// Sequencer events, same clock domain
	input  wire        SEQ_DONE,
	input  wire        RX_LEN_DONE,
	input  wire        RX_IS_BEACON,
	input  wire        TX_LEN_DONE,
	input  wire        SEQ_IS_TX,
	// Timebase outputs
	output reg  [31:0] ABS_CLOCK,
	output reg  [31:0] REL_CLOCK,
	output wire [6:0]  BACKOFF_COUNT,
	output reg         SLOT_ACCESS
);

	// Prescaler width sized from the tick period
	localparam PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam integer PRE_LAST = TICK_CYCLES - 1;

	reg  [PRE_W-1:0] pre_reg;
	reg  [PRE_W-1:0] pre_next;
	reg              tick_reg;
	reg              tick_next;

	reg  [31:0]      abs_reg;
	reg  [31:0]      abs_next;
	reg  [31:0]      offset_reg;
	reg  [31:0]      offset_next;
	reg  [31:0]      done_stamp_reg;
	reg  [31:0]      done_stamp_next;
	reg  [31:0]      rx_stamp_reg;
	reg  [31:0]      rx_stamp_next;
	reg  [31:0]      slot_reg;
	reg  [31:0]      slot_next;
	reg  [2:0]       ctrl_reg;
	reg  [2:0]       ctrl_next;

	// Write channel holding state
	reg              aw_hold_reg;
	reg              aw_hold_next;
	reg  [7:0]       aw_addr_reg;
	reg              w_hold_reg;
	reg              w_hold_next;
	reg  [31:0]      w_data_reg;
	reg  [3:0]       w_strb_reg;
	reg              bvalid_next;
	reg  [1:0]       bresp_next;
	reg              rvalid_next;
	reg  [31:0]      rdata_next;
	reg  [1:0]       rresp_next;

	wire             aw_take;
	wire             w_take;
	wire             ar_take;
	wire             do_write;
	wire [31:0]      rel_now;
	wire [31:0]      stamp_src;
	wire             wr_abs;
	wire             wr_offset;
	wire             wr_rel;
	wire             wr_slot;
	wire             wr_ctrl;
	wire             wr_known;
	wire             load_rx;
	wire             load_tx;
	wire             load_any;
	wire [11:0]      load_value;
	wire             backoff_wrap;
	reg  [31:0]      rd_word;
	reg              rd_known;

	// Byte-lane merge for partial writes
	function [31:0] merge_lanes;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0]  strb;
		integer      i;
		begin
			merge_lanes = old_word;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge_lanes[i*8 +: 8] = new_word[i*8 +: 8];
				end
			end
		end
	endfunction

	assign aw_take  = S_AXI_AWVALID & S_AXI_AWREADY;
	assign w_take   = S_AXI_WVALID & S_AXI_WREADY;
	assign ar_take  = S_AXI_ARVALID & S_AXI_ARREADY;
	assign do_write = aw_hold_reg & w_hold_reg & ~S_AXI_BVALID;

	// Address decode of the held write
	assign wr_abs    = do_write & (aw_addr_reg == `MRTB_ADDR_ABS_CLOCK);
	assign wr_offset = do_write & (aw_addr_reg == `MRTB_ADDR_CLOCK_OFFSET);
	assign wr_rel    = do_write & (aw_addr_reg == `MRTB_ADDR_RELATIVE);
	assign wr_slot   = do_write & (aw_addr_reg == `MRTB_ADDR_SLOT_ALIGN);
	assign wr_ctrl   = do_write & (aw_addr_reg == `MRTB_ADDR_CONTROL);
	// Stamp registers accept the write cycle but keep their value
	assign wr_known  = wr_abs | wr_offset | wr_rel | wr_slot | wr_ctrl
		| (aw_addr_reg == `MRTB_ADDR_DONE_STAMP) | (aw_addr_reg == `MRTB_ADDR_RX_STAMP);

	// Relative clock is never stored apart from its parts
	assign rel_now   = abs_reg + offset_reg;
	assign stamp_src = ctrl_reg[`MRTB_CTRL_SEL_REL] ? rel_now : abs_reg;

	// Backoff reload sources; rx beacon wins if both land together
	assign load_rx    = ctrl_reg[`MRTB_CTRL_RELOAD] & RX_LEN_DONE & RX_IS_BEACON;
	assign load_tx    = ctrl_reg[`MRTB_CTRL_RELOAD] & TX_LEN_DONE & SEQ_IS_TX;
	assign load_any   = load_rx | load_tx;
	assign load_value = load_rx ? slot_reg[`MRTB_RX_SLOT_MSB:`MRTB_RX_SLOT_LSB]
		: slot_reg[`MRTB_TX_SLOT_MSB:`MRTB_TX_SLOT_LSB];

	// Backoff counter ticks at four times the symbol rate
	mrtb_backoff #(
		.LOAD_W     (12)
	) u_backoff (
		.clk        (CORE_CLK),
		.rst_n      (RST_N),
		.tick       (tick_reg),
		.load       (load_any),
		.load_value (load_value),
		.count_reg  (BACKOFF_COUNT),
		.wrap_reg   (backoff_wrap)
	);

	// 250 kHz tick from the core clock
	always @* begin
		tick_next = 1'b0;
		pre_next  = pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
		if (pre_reg >= PRE_LAST) begin
			pre_next  = {PRE_W{1'b0}};
			tick_next = 1'b1;
		end
	end

	// Absolute clock and offset; an absolute write beats a tick in the same cycle
	always @* begin
		abs_next    = abs_reg;
		offset_next = offset_reg;
		if (tick_reg) begin
			abs_next = abs_reg + 32'h00000001;
		end
		if (wr_abs) begin
			abs_next = merge_lanes(abs_reg, w_data_reg, w_strb_reg);
		end
		if (wr_offset) begin
			offset_next = merge_lanes(offset_reg, w_data_reg, w_strb_reg);
		end else if (wr_rel) begin
			// Offset chases the written value; the ongoing tick is kept
			offset_next = merge_lanes(rel_now, w_data_reg, w_strb_reg) - abs_reg;
		end
		// No trigger compare value lives here; a rewrite touches none of them
	end

	// Timestamp capture; unchanged otherwise
	always @* begin
		done_stamp_next = done_stamp_reg;
		rx_stamp_next   = rx_stamp_reg;
		if (SEQ_DONE) begin
			done_stamp_next = stamp_src;
		end
		if (RX_LEN_DONE) begin
			rx_stamp_next = stamp_src;
		end
	end

	// Software-owned configuration
	always @* begin
		slot_next = slot_reg;
		ctrl_next = ctrl_reg;
		if (wr_slot) begin
			slot_next = merge_lanes(slot_reg, w_data_reg, w_strb_reg) & `MRTB_SLOT_MASK;
		end
		if (wr_ctrl & w_strb_reg[0]) begin
			ctrl_next = w_data_reg[2:0];
		end
	end

	// Write channel: address and data may arrive in either order
	always @* begin
		aw_hold_next = aw_hold_reg;
		w_hold_next  = w_hold_reg;
		bvalid_next  = S_AXI_BVALID;
		bresp_next   = S_AXI_BRESP;
		if (aw_take) begin
			aw_hold_next = 1'b1;
		end
		if (w_take) begin
			w_hold_next = 1'b1;
		end
		if (do_write) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_known ? `MRTB_RESP_OKAY : `MRTB_RESP_SLVERR;
		end else if (S_AXI_BVALID & S_AXI_BREADY) begin
			bvalid_next = 1'b0;
		end
	end

	// Read mux; unmapped addresses answer zero with an error
	always @* begin
		rd_word  = `MRTB_RST_WORD;
		rd_known = 1'b1;
		if (S_AXI_ARADDR == `MRTB_ADDR_ABS_CLOCK) begin
			rd_word = abs_reg;
		end else if (S_AXI_ARADDR == `MRTB_ADDR_CLOCK_OFFSET) begin
			rd_word = offset_reg;
		end else if (S_AXI_ARADDR == `MRTB_ADDR_RELATIVE) begin
			rd_word = rel_now;
		end else if (S_AXI_ARADDR == `MRTB_ADDR_DONE_STAMP) begin
			rd_word = done_stamp_reg;
		end else if (S_AXI_ARADDR == `MRTB_ADDR_SLOT_ALIGN) begin
			rd_word = slot_reg;
		end else if (S_AXI_ARADDR == `MRTB_ADDR_RX_STAMP) begin
			rd_word = rx_stamp_reg;
		end else if (S_AXI_ARADDR == `MRTB_ADDR_CONTROL) begin
			rd_word = {29'h00000000, ctrl_reg};
		end else if (S_AXI_ARADDR == `MRTB_ADDR_STATUS) begin
			rd_word = {23'h000000, SLOT_ACCESS, 1'b0, BACKOFF_COUNT};
		end else begin
			rd_known = 1'b0;
		end
	end

	// Read channel: answer one cycle after the address is taken
	always @* begin
		rvalid_next = S_AXI_RVALID;
		rdata_next  = S_AXI_RDATA;
		rresp_next  = S_AXI_RRESP;
		if (ar_take) begin
			rvalid_next = 1'b1;
			rdata_next  = rd_word;
			rresp_next  = rd_known ? `MRTB_RESP_OKAY : `MRTB_RESP_SLVERR;
		end else if (S_AXI_RVALID & S_AXI_RREADY) begin
			rvalid_next = 1'b0;
		end
	end

	// Timebase state
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pre_reg        <= {PRE_W{1'b0}};
			tick_reg       <= 1'b0;
			abs_reg        <= `MRTB_RST_WORD;
			offset_reg     <= `MRTB_RST_WORD;
			done_stamp_reg <= `MRTB_RST_WORD;
			rx_stamp_reg   <= `MRTB_RST_WORD;
			slot_reg       <= `MRTB_RST_WORD;
			ctrl_reg       <= `MRTB_RST_CONTROL;
			ABS_CLOCK      <= `MRTB_RST_WORD;
			REL_CLOCK      <= `MRTB_RST_WORD;
			SLOT_ACCESS    <= 1'b0;
		end else begin
			pre_reg        <= pre_next;
			tick_reg       <= tick_next;
			abs_reg        <= abs_next;
			offset_reg     <= offset_next;
			done_stamp_reg <= done_stamp_next;
			rx_stamp_reg   <= rx_stamp_next;
			slot_reg       <= slot_next;
			ctrl_reg       <= ctrl_next;
			// Copies track the live values one cycle late
			ABS_CLOCK      <= abs_reg;
			REL_CLOCK      <= rel_now;
			// Outside slotted mode the channel is always open
			SLOT_ACCESS    <= ~ctrl_reg[`MRTB_CTRL_SLOTTED] | backoff_wrap;
		end
	end

	// Bus slave state
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_hold_reg   <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_hold_reg    <= 1'b0;
			w_data_reg    <= `MRTB_RST_WORD;
			w_strb_reg    <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `MRTB_RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= `MRTB_RST_WORD;
			S_AXI_RRESP   <= `MRTB_RESP_OKAY;
		end else begin
			aw_hold_reg   <= aw_hold_next;
			w_hold_reg    <= w_hold_next;
			if (aw_take) begin
				aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
			end
			if (w_take) begin
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			// Ready drops while a beat is held, so one write at a time
			S_AXI_AWREADY <= ~aw_hold_next & ~bvalid_next;
			S_AXI_WREADY  <= ~w_hold_next & ~bvalid_next;
			S_AXI_BVALID  <= bvalid_next;
			S_AXI_BRESP   <= bresp_next;
			S_AXI_ARREADY <= ~rvalid_next;
			S_AXI_RVALID  <= rvalid_next;
			S_AXI_RDATA   <= rdata_next;
			S_AXI_RRESP   <= rresp_next;
		end
	end

endmodule // mrtb_timebase

/* mrtb_defines.vh */
`ifndef MRTB_DEFINES_VH
`define MRTB_DEFINES_VH

// Register byte offsets
`define MRTB_ADDR_ABS_CLOCK     8'h48
`define MRTB_ADDR_CLOCK_OFFSET  8'h58
`define MRTB_ADDR_RELATIVE      8'h5c
`define MRTB_ADDR_DONE_STAMP    8'h60
`define MRTB_ADDR_SLOT_ALIGN    8'h64
`define MRTB_ADDR_RX_STAMP      8'h68
`define MRTB_ADDR_CONTROL       8'h6c
`define MRTB_ADDR_STATUS        8'h70

// Reset values
`define MRTB_RST_WORD           32'h00000000
`define MRTB_RST_CONTROL        3'h0

// Control register bit positions
`define MRTB_CTRL_SEL_REL       0
`define MRTB_CTRL_RELOAD        1
`define MRTB_CTRL_SLOTTED       2

// Slot alignment fields and writable mask
`define MRTB_RX_SLOT_MSB        27
`define MRTB_RX_SLOT_LSB        16
`define MRTB_TX_SLOT_MSB        11
`define MRTB_TX_SLOT_LSB        0
`define MRTB_SLOT_MASK          32'h0fff0fff

// Status register bit positions
`define MRTB_STAT_IN_SLOT       8

// Backoff counter span, quarter symbols
`define MRTB_BACKOFF_LAST       7'h4f
`define MRTB_BACKOFF_SPAN       80

// Timing: core clock and timebase tick rate
`define MRTB_CORE_HZ            10000000
`define MRTB_TICK_HZ            250000
`define MRTB_TICK_CYCLES        (`MRTB_CORE_HZ / `MRTB_TICK_HZ)

// AXI responses
`define MRTB_RESP_OKAY          2'h0
`define MRTB_RESP_SLVERR        2'h2

`endif

/* mrtb_backoff.v */
`timescale 1ns/1ps
`include "mrtb_defines.vh"

module mrtb_backoff #(
	parameter LOAD_W = 12
) (
	input  wire              clk,
	input  wire              rst_n,
	input  wire              tick,
	input  wire              load,
	input  wire [LOAD_W-1:0] load_value,
	output reg  [6:0]        count_reg,
	output reg               wrap_reg
);

	reg  [6:0]        count_next;
	reg               wrap_next;
	wire [31:0]       load_mod;

	// Offset beyond the span folds back into 0..79
	assign load_mod = load_value % `MRTB_BACKOFF_SPAN;

	// Counter next state; a load realigns the slot grid
	always @* begin
		count_next = count_reg;
		wrap_next  = 1'b0;
		if (load) begin
			count_next = load_mod[6:0];
		end else if (tick) begin
			if (count_reg >= `MRTB_BACKOFF_LAST) begin
				count_next = 7'h00;
				wrap_next  = 1'b1;
			end else begin
				count_next = count_reg + 7'h01;
			end
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 7'h00;
			wrap_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			wrap_reg  <= wrap_next;
		end
	end

endmodule // mrtb_backoff

/* mrtb_timebase_monitor.sv */
`timescale 1ns/1ps
module mrtb_timebase_monitor (
	input wire        CORE_CLK,
	input wire        RST_N,
	input wire        S_AXI_AWVALID,
	input wire        S_AXI_AWREADY,
	input wire        S_AXI_WVALID,
	input wire        S_AXI_WREADY,
	input wire [1:0]  S_AXI_BRESP,
	input wire        S_AXI_BVALID,
	input wire        S_AXI_BREADY,
	input wire        RX_LEN_DONE,
	input wire        TX_LEN_DONE,
	input wire [31:0] ABS_CLOCK,
	input wire [31:0] REL_CLOCK,
	input wire [6:0]  BACKOFF_COUNT,
	input wire        SLOT_ACCESS
);
	// Offset as seen at the ports; only a register write may move it
	wire [31:0] rel_gap = REL_CLOCK - ABS_CLOCK;
	default clocking dc @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// Writes are excused through the cycle after the response rises
	property p_abs_step; !$stable(ABS_CLOCK) && !$past(S_AXI_BVALID) |-> ABS_CLOCK == $past(ABS_CLOCK) + 32'h1; endproperty
	a_abs_step: assert property (p_abs_step) else $error("abs clock jump");
	property p_rel_gap; !$past(S_AXI_BVALID) |-> rel_gap == $past(rel_gap); endproperty
	a_rel_gap: assert property (p_rel_gap) else $error("relative drift");
	property p_bo_max; BACKOFF_COUNT <= 7'h4f; endproperty
	a_bo_max: assert property (p_bo_max) else $error("backoff range");
	// Free run wraps 79 to 0; length events may load it
	property p_bo_step;
		!$stable(BACKOFF_COUNT) && !$past(RX_LEN_DONE) && !$past(TX_LEN_DONE)
			|-> BACKOFF_COUNT == (($past(BACKOFF_COUNT) == 7'h4f) ? 7'h00 : $past(BACKOFF_COUNT) + 7'h01);
	endproperty
	a_bo_step: assert property (p_bo_step) else $error("backoff step");
	// A one-cycle opening only comes from a wrap; leaving slotted mode is a long high
	property p_slot; $fell(SLOT_ACCESS) && !$past(SLOT_ACCESS, 2) |-> $past(BACKOFF_COUNT) < 7'h02; endproperty
	a_slot: assert property (p_slot) else $error("slot off wrap");
	property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
	a_b_hold: assert property (p_b_hold) else $error("response dropped");
	property p_aw_block; S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY[*2]; endproperty
	a_aw_block: assert property (p_aw_block) else $error("second write open");
	property p_b_lat; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID; endproperty
	a_b_lat: assert property (p_b_lat) else $error("response late");
	c_wrap: cover property (BACKOFF_COUNT == 7'h4f ##1 BACKOFF_COUNT == 7'h00);
	c_load: cover property (RX_LEN_DONE || TX_LEN_DONE);
	c_slot: cover property ($fell(SLOT_ACCESS));
endmodule // mrtb_timebase_monitor
bind mrtb_timebase mrtb_timebase_monitor u_mon (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .RX_LEN_DONE(RX_LEN_DONE),
	.TX_LEN_DONE(TX_LEN_DONE), .ABS_CLOCK(ABS_CLOCK), .REL_CLOCK(REL_CLOCK),
	.BACKOFF_COUNT(BACKOFF_COUNT), .SLOT_ACCESS(SLOT_ACCESS)
);

/* mac_relative_timebase_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module mac_relative_timebase_tb_top;
	localparam TK = 4;
	logic        clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdv;
	logic [3:0]  wstrb = 4'h0;
	logic [4:0]  ev = 5'h0;
	logic [1:0]  resp;
	wire         awready, wready, bvalid, arready, rvalid, slot;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata, abs_clk, rel_clk;
	wire [6:0]   bo;
	int          bad_count = 0, cmp_count = 0;
	// Prescaler shortened so a backoff round takes 320 cycles
	mrtb_timebase #(.TICK_CYCLES(TK)) dut (
		.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.SEQ_DONE(ev[4]), .RX_LEN_DONE(ev[3]), .RX_IS_BEACON(ev[2]), .TX_LEN_DONE(ev[1]), .SEQ_IS_TX(ev[0]),
		.ABS_CLOCK(abs_clk), .REL_CLOCK(rel_clk), .BACKOFF_COUNT(bo), .SLOT_ACCESS(slot)
	);
	always #50 clk = ~clk;
	// Write; each channel dropped once taken, response ready held from the start
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] p, q;
		logic       k;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		p = 2'h3;
		k = 1'b0;
		while (k !== 1'b1) begin
			@(negedge clk);
			q = p & {awready, wready};
			k = bvalid;
			resp = bresp;
			@(posedge clk);
			p = p & ~q;
			awvalid <= p[1];
			wvalid <= p[0];
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic k;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 1'b0;
		while (k !== 1'b1) begin
			@(negedge clk);
			k = arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		k = 1'b0;
		while (k !== 1'b1) begin
			@(negedge clk);
			k = rvalid;
			rdv = rdata;
			resp = rresp;
			@(posedge clk);
		end
		rready <= 1'b0;
	endtask
	// One-cycle sequencer event, outputs settled on return
	task automatic pulse(input logic [4:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 5'h0;
		#1;
	endtask
	// Cycles until the next slot opening
	task automatic ws(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (slot === 1'b1 && n < 999);
		do begin
			@(negedge clk);
			n++;
		end while (slot !== 1'b1 && n < 999);
	endtask
	task automatic t_reset;
		logic [7:0] ad[6] = '{8'h00, 8'h58, 8'h60, 8'h64, 8'h68, 8'h6c};
		foreach (ad[i]) begin
			rd(ad[i]);
			`CHK(rdv, 32'h0)
			`CHK(resp, (ad[i] == 8'h00) ? 2'h2 : 2'h0)
		end
		wr(8'h00, 32'h1, 4'hf);
		`CHK(resp, 2'h2)
	endtask
	task automatic t_clock;
		logic [31:0] a0;
		wr(8'h58, 32'h1000_0000, 4'hf);
		@(posedge clk);
		#1;
		a0 = abs_clk;
		`CHK(rel_clk - abs_clk, 32'h1000_0000)
		repeat (5 * TK) @(posedge clk);
		#1;
		`CHK(abs_clk - a0, 32'h5)
		`CHK(rel_clk - abs_clk, 32'h1000_0000)
		// No compare timer runs here, so a relative rewrite is safe
		wr(8'h5c, 32'h5, 4'hf);
		rd(8'h58);
		#1;
		`CHK(rel_clk - abs_clk, rdv)
		`CHK(rel_clk < 32'h10, 1'b1)
		wr(8'h48, 32'hffff_fffe, 4'hf);
		repeat (3 * TK) @(posedge clk);
		#1;
		`CHK(abs_clk < 32'h4, 1'b1)
		`CHK(rel_clk - abs_clk, rdv)
	endtask
	// Stamps follow the clock select and ignore writes
	task automatic t_stamp;
		logic [31:0] e;
		wr(8'h6c, 32'h0, 4'hf);
		pulse(5'h10);
		e = abs_clk;
		rd(8'h60);
		`CHK(rdv, e)
		wr(8'h6c, 32'h1, 4'hf);
		pulse(5'h08);
		e = rel_clk;
		wr(8'h68, 32'h1234_5678, 4'hf);
		`CHK(resp, 2'h0)
		rd(8'h68);
		`CHK(rdv, e)
	endtask
	// Field masking, byte lanes, reloads, slotted openings
	task automatic t_slot;
		int n;
		wr(8'h64, 32'hffff_ffff, 4'hf);
		rd(8'h64);
		`CHK(rdv, 32'h0fff_0fff)
		wr(8'h64, 32'h0055_001e, 4'hf);
		wr(8'h64, 32'hff42_ffff, 4'h4);
		rd(8'h64);
		`CHK(rdv, 32'h0042_001e)
		wr(8'h6c, 32'h2, 4'hf);
		pulse(5'h0c);
		`CHK(bo, 7'h42)
		pulse(5'h03);
		`CHK(bo, 7'h1e)
		wr(8'h6c, 32'h0, 4'hf);
		pulse(5'h0e);
		`CHK(bo !== 7'h42, 1'b1)
		wr(8'h6c, 32'h4, 4'hf);
		ws(n);
		`CHK(bo < 7'h02, 1'b1)
		ws(n);
		`CHK(n, 80 * TK)
	endtask
	task automatic conclude;
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Hang guard, well past the expected run of under a thousand cycles
	initial begin
		#2_000_000;
		bad_count++;
		conclude;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		t_clock;
		t_stamp;
		t_slot;
		conclude;
	end
endmodule // mac_relative_timebase_tb_top
